// *** sim/sbs_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbs_peer
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // engine requests
  input wire logic go,
  input wire logic stop,
  // engine events
  output var logic busy,
  output var logic rx_done,
  output var logic tx_took
);
  logic [5:0] n;
  // a byte aborted before its last cycle (n == 1) never completes, so no receive event follows
  always @(posedge clk_sys)
  begin
    rx_done <= !go && busy && n == 6'h01;
    tx_took <= go;
    if (rst || stop)
      busy <= 1'b0;
    else if (go)
      busy <= 1'b1;
    else if (n == 6'h01)
      busy <= 1'b0;
    n <= go ? 6'h28 : n - 6'h01;
  end
endmodule // sbs_peer
`default_nettype wire

// *** sim/sbs_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbs_chk
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // control levels
  input wire logic port_enable,
  input wire logic rx_fault_irq_enable,
  input wire logic tx_empty_irq_enable,
  // watched outputs
  input wire logic tx_data_valid,
  input wire logic irq,
  input wire logic [7:0] status_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_flags_after_reset: assert property ($fell(rst) |-> status_register == 8'h20)
    else $error("reset flags");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("rdata not idle");
  a_status_read: assert property (reg_rd && reg_addr == 8'heb |=> reg_rdata == $past(status_register))
    else $error("status read");
  a_unused_zero: assert property ((status_register & 8'h4f) == 8'h00)
    else $error("unused status bits");
  a_tx_irq: assert property (status_register[5] && tx_empty_irq_enable |-> irq)
    else $error("tx irq");
  a_fault_irq: assert property (status_register[4] && rx_fault_irq_enable |-> irq)
    else $error("fault irq");
  a_off_flags: assert property (!port_enable |=> status_register == 8'h20)
    else $error("disable flags");
  a_accept_write: assert property (tx_data_valid |-> reg_wr && reg_addr == 8'hed)
    else $error("accept without write");
endmodule // sbs_chk
bind sbs_top sbs_chk sbs_chk_inst(.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .port_enable(port_enable), .irq(irq), .tx_data_valid(tx_data_valid),
  .rx_fault_irq_enable(rx_fault_irq_enable), .tx_empty_irq_enable(tx_empty_irq_enable),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .status_register(status_register));
`default_nettype wire

// *** sim/tb_sbs_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_sbs_top;
  logic c = 0, r = 1, w = 0, rd = 0, pe = 1, mm = 1, fd = 0, ri = 0, ti = 0, ss = 1;
  logic xa, rb, tl, ab, tv, sk, se, q;
  logic [7:0] a = 0, d = 0, rq, st, td;
  int n_errors = 0, samples_checked = 0, k;
  sbs_top sbs_top_inst(.clk_sys(c), .rst(r), .reg_addr(a), .reg_wdata(d), .reg_wr(w),
    .reg_rd(rd), .reg_rdata(rq), .port_enable(pe), .master_mode(mm), .fault_detect_enable(fd),
    .rx_fault_irq_enable(ri), .tx_empty_irq_enable(ti), .ss_in_n(ss), .xfer_active(xa),
    .rx_byte_done(rb), .tx_loaded(tl), .engine_abort(ab), .tx_data_valid(tv), .tx_data(td),
    .sclk(sk), .sclk_edge(se), .status_register(st), .irq(q));
  sbs_peer sbs_peer_inst(.clk_sys(c), .rst(r), .go(tv), .stop(ab), .busy(xa),
    .rx_done(rb), .tx_took(tl));
  initial forever #20 c = ~c;
  task chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] x, y);
    @(posedge c);
    a <= x;
    d <= y;
    w <= 1;
    @(posedge c);
    w <= 0;
  endtask
  task rdc(input logic [7:0] x, e, m);
    @(posedge c);
    a <= x;
    rd <= 1;
    @(posedge c);
    rd <= 0;
    #1 chk(rq & m, e);
  endtask
  task test_done;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task t_regs;
    rdc(8'hea, 8'h00, 8'hff);
    rdc(8'heb, 8'h20, 8'hff);
    wr(8'hea, 8'hff);
    wr(8'heb, 8'h00);
    rdc(8'hea, 8'h77, 8'hff);
    rdc(8'heb, 8'h20, 8'hff);
    rdc(8'hee, 8'h00, 8'hff);
    wr(8'hea, 8'h11);
  endtask
  task t_tx;
    rdc(8'heb, 8'h20, 8'hff);
    wr(8'hed, 8'ha5);
    #1 chk(st, 8'h00);
    chk(td, 8'ha5);
    // the accept above used up the arming, so this write must bounce
    wr(8'hed, 8'h5a);
    #1 chk(st, 8'h20);
    chk(td, 8'ha5);
    for (k = 0; k < 99 && !se; k++)
      #40;
    chk({7'h00, sk}, 8'h01);
    for (k = 0; k == 0 || (!se && k < 99); k++)
      #40;
    chk(k[7:0], 8'h04);
    wr(8'hea, 8'h12);
    #1 chk({7'h00, xa}, 8'h00);
    rdc(8'heb, 8'h20, 8'hff);
    wr(8'hed, 8'h3c);
    // no data path lives here, so a data read returns zero
    #2000 rdc(8'hed, 8'h00, 8'hff);
    rdc(8'heb, 8'ha0, 8'hff);
    rdc(8'hed, 8'h00, 8'hff);
    rdc(8'heb, 8'h20, 8'hff);
  endtask
  task t_fault;
    @(posedge c);
    ri <= 1;
    fd <= 1;
    ss <= 0;
    rdc(8'heb, 8'h30, 8'hff);
    chk({7'h00, q}, 8'h01);
    wr(8'he8, 8'h00);
    rdc(8'heb, 8'h20, 8'hff);
    chk({7'h00, q}, 8'h00);
    @(posedge c);
    ss <= 1;
    ti <= 1;
    @(posedge c);
    ss <= 0;
    // mode fault not yet set here, so only the empty flag can raise irq
    #1 chk({7'h00, q}, 8'h01);
    #89 chk(st, 8'h30);
    @(posedge c);
    pe <= 0;
    #90 chk(st, 8'h20);
    chk({7'h00, ab}, 8'h01);
  endtask
  initial
  begin
    repeat (12) @(posedge c);
    r <= 0;
    t_regs;
    t_tx;
    t_fault;
    test_done;
  end
  initial
  begin
    #100000;
    n_errors++;
    test_done;
  end
endmodule // tb_sbs_top
`default_nettype wire

// *** verilog/sbs_map.vh ***
// Summary of operation
// (R1) divisor is (prescale plus one) times two to the (exponent plus one)
// (R2) serial clock runs at bus clock divided by the divisor
// (R3) in master mode a change of either rate field aborts and idles engine
// (R4) rate register reads and writes anytime; reserved bit stays zero
// (R5) status register writes have no effect; reads allowed anytime
// (R6) receive-complete bit 7 sets when received byte lands in data register
// (R7) receive-complete clears after status read with it set, then data read
// (R8) transmit-empty bit 5 high while transmit register empty; one at reset
// (R9) data accepted, transmit-empty cleared, only after status read then data write
// (R10) data write without prior status read showing transmit-empty is ignored
// (R11) mode fault bit 4 sets when select goes low in master with detect on
// (R12) mode fault clears after status read with it set, then control-1 write
// (R13) interrupt requested when mode fault set and receive/fault enable set
// (R14) interrupt requested while transmit-empty set and its enable is one
// (R15) clearing port enable idles engine and resets all status flags
// (R16) serial clock toggles every half divisor, one period spans the divisor
`ifndef SBS_MAP_VH
`define SBS_MAP_VH
`define SBS_ADDR_W 8
`define SBS_OFF_CTRL1 8'he8
`define SBS_OFF_RATE 8'hea
`define SBS_OFF_STATUS 8'heb
`define SBS_OFF_DATA 8'hed
`define SBS_RATE_MASK 8'h77
`define SBS_RATE_RESET 8'h00
`define SBS_STATUS_RESET 8'h20
`define SBS_BIT_RXC 7
`define SBS_BIT_TXE 5
`define SBS_BIT_MODE_FAULT_FLAG 4
`define SBS_PRE_LSB 4
`define SBS_EXP_LSB 0
`define SBS_FIELD_W 3
`define SBS_DIV_W 12
`endif

// *** verilog/sbs_rate_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.vh"
module sbs_rate_gen
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // control
  input wire run,
  input wire [`SBS_FIELD_W-1:0] prescale,
  input wire [`SBS_FIELD_W-1:0] exponent,
  // serial clock
  output reg sclk,
  output reg sclk_edge
);
  wire [`SBS_DIV_W-1:0] half_div;
  reg [`SBS_DIV_W-1:0] count;
  // half of (p+1)*2^(e+1) is (p+1)<<e
  assign half_div = {{(`SBS_DIV_W-`SBS_FIELD_W-1){1'b0}}, {1'b0, prescale} + 4'h1} << exponent; // R1
  always @(posedge clk_sys)
  begin
    if (rst || !run)
    begin
      count <= {`SBS_DIV_W{1'b0}};
      sclk <= 1'b0;
      sclk_edge <= 1'b0;
    end
    else if (count == half_div - 12'h001)
    begin
      count <= {`SBS_DIV_W{1'b0}};
      sclk <= ~sclk; // R2 R16
      sclk_edge <= 1'b1;
    end
    else
    begin
      count <= count + 12'h001;
      sclk_edge <= 1'b0;
    end
  end
endmodule // sbs_rate_gen
`default_nettype wire

// *** verilog/sbs_status.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.vh"
module sbs_status
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire port_enable,
  // events
  input wire rx_done,
  input wire fault_set,
  input wire tx_taken,
  // software accesses
  input wire status_rd,
  input wire data_rd,
  input wire data_wr,
  input wire ctrl1_wr,
  // flags
  output reg rx_complete_flag,
  output reg tx_empty_flag,
  output reg mode_fault_flag,
  output wire tx_accept
);
  reg rx_armed;
  reg tx_armed;
  reg mf_armed;
  // a status read in the same cycle cannot arm; strobes never overlap anyway
  assign tx_accept = data_wr && tx_armed && tx_empty_flag; // R9 R10
  always @(posedge clk_sys)
  begin
    if (rst || !port_enable) // R15
    begin
      rx_complete_flag <= 1'b0;
      tx_empty_flag <= 1'b1; // R8
      mode_fault_flag <= 1'b0;
      rx_armed <= 1'b0;
      tx_armed <= 1'b0;
      mf_armed <= 1'b0;
    end
    else
    begin
      if (status_rd)
      begin
        rx_armed <= rx_complete_flag;
        tx_armed <= tx_empty_flag;
        mf_armed <= mode_fault_flag;
      end
      // set wins over clear
      if (rx_done)
        rx_complete_flag <= 1'b1; // R6
      else if (data_rd && rx_armed)
        rx_complete_flag <= 1'b0; // R7
      if (data_rd)
        rx_armed <= 1'b0;
      if (tx_taken)
        tx_empty_flag <= 1'b1; // R8
      else if (tx_accept)
        tx_empty_flag <= 1'b0; // R9
      if (tx_accept)
        tx_armed <= 1'b0;
      if (fault_set)
        mode_fault_flag <= 1'b1; // R11
      else if (ctrl1_wr && mf_armed)
        mode_fault_flag <= 1'b0; // R12
      if (ctrl1_wr)
        mf_armed <= 1'b0;
    end
  end
endmodule // sbs_status
`default_nettype wire

// *** verilog/sbs_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sbs_map.vh"
module sbs_top
(
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input wire [`SBS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // control from the rest of the port
  input wire port_enable,
  input wire master_mode,
  input wire fault_detect_enable,
  input wire rx_fault_irq_enable,
  input wire tx_empty_irq_enable,
  input wire ss_in_n,
  // engine side
  input wire xfer_active,
  input wire rx_byte_done,
  input wire tx_loaded,
  output wire engine_abort,
  output wire tx_data_valid,
  output reg [7:0] tx_data,
  // serial clock and flags
  output wire sclk,
  output wire sclk_edge,
  output wire [7:0] status_register,
  output wire irq
);
  reg [7:0] rate_select_register;
  reg ss_prev_n;
  wire rate_wr;
  wire rate_change;
  wire fault_set;
  wire rx_complete_flag;
  wire tx_empty_flag;
  wire mode_fault_flag;
  wire sel_status;
  wire sel_data;
  assign sel_status = reg_addr == `SBS_OFF_STATUS;
  assign sel_data = reg_addr == `SBS_OFF_DATA;
  assign rate_wr = reg_wr && reg_addr == `SBS_OFF_RATE;
  assign rate_change = rate_wr &&
    ((reg_wdata & `SBS_RATE_MASK) != rate_select_register);
  assign engine_abort = !port_enable || (master_mode && rate_change); // R3 R15
  // fault on the falling select edge only
  assign fault_set = port_enable && master_mode && fault_detect_enable &&
    ss_prev_n && !ss_in_n; // R11
  assign status_register = {rx_complete_flag, 1'b0, tx_empty_flag, mode_fault_flag, 4'h0};
  assign irq = (mode_fault_flag && rx_fault_irq_enable) || (rx_complete_flag && rx_fault_irq_enable)
    || (tx_empty_flag && tx_empty_irq_enable); // R13 R14
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rate_select_register <= `SBS_RATE_RESET;
      ss_prev_n <= 1'b1;
      reg_rdata <= 8'h00;
      tx_data <= 8'h00;
    end
    else
    begin
      ss_prev_n <= ss_in_n;
      if (rate_wr)
        rate_select_register <= reg_wdata & `SBS_RATE_MASK; // R4
      if (tx_data_valid)
        tx_data <= reg_wdata;
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          `SBS_OFF_RATE: reg_rdata <= rate_select_register; // R4
          `SBS_OFF_STATUS: reg_rdata <= status_register; // R5
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
  sbs_rate_gen sbs_rate_gen_inst
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(port_enable && master_mode && xfer_active && !engine_abort),
    .prescale(rate_select_register[`SBS_PRE_LSB+2:`SBS_PRE_LSB]),
    .exponent(rate_select_register[`SBS_EXP_LSB+2:`SBS_EXP_LSB]),
    .sclk(sclk),
    .sclk_edge(sclk_edge)
  );
  sbs_status sbs_status_inst
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .port_enable(port_enable),
    .rx_done(rx_byte_done),
    .fault_set(fault_set),
    .tx_taken(tx_loaded),
    .status_rd(reg_rd && sel_status),
    .data_rd(reg_rd && sel_data),
    .data_wr(reg_wr && sel_data),
    .ctrl1_wr(reg_wr && reg_addr == `SBS_OFF_CTRL1),
    .rx_complete_flag(rx_complete_flag),
    .tx_empty_flag(tx_empty_flag),
    .mode_fault_flag(mode_fault_flag),
    .tx_accept(tx_data_valid)
  );
endmodule // sbs_top
`default_nettype wire
